// File: logic/trim_regs.svh
/*
 * Register map, field layout, reset values and widths of the auxiliary
 * channel gain and offset trim block.
 * Assumes inclusion by bare name from every file that needs the map.
 */
`ifndef TRIM_REGS_SVH
`define TRIM_REGS_SVH

// byte addresses of the trim registers
`define OFS_GAIN_TRIM_AMP_GAIN_TWO    32'h0000_2274
`define OFS_GAIN_TRIM_AMP_GAIN_FOUR   32'h0000_2278
`define OFS_OFFSET_TRIM_AMP_GAIN_FOUR 32'h0000_22d4
// status word of the correction path
`define OFS_TRIM_STATUS               32'h0000_22e0

// trim field sits in bits [14:0], the rest reads as zero
`define TRIM_FIELD_MSB   14
`define TRIM_FIELD_W     15
`define TRIM_FIELD_MASK  32'h0000_7fff

// reset values
`define RST_GAIN_TRIM    32'h0000_4000
`define RST_OFFSET_TRIM  32'h0000_0000

// gain and offset codes with a fixed meaning
`define TRIM_GAIN_UNITY  15'h4000
`define TRIM_GAIN_ZERO   15'h0000
`define TRIM_OFFSET_NONE 15'h0000

// fractional bits: 14 of gain, 2 of quarter-code offset
`define TRIM_GAIN_FRAC   14
`define TRIM_QTR_BITS    2
`define TRIM_SHIFT       16

// status word fields
`define STAT_SAT_BIT     16
`define STAT_TRIM_BIT    17

// widths of the data path
`define CODE_W           16
`define QTR_W            20
`define PROD_W           36
`define CODE_MAX         16'hffff

`endif

// File: logic/trim_pkg.sv
/*
 * Types shared by the trim block: amplifier gain settings and the kind
 * of channel that produced a conversion.
 * Assumes the converter front end encodes both as below.
 */
package trim_pkg;

	// amplifier gain setting in force for a conversion
	typedef enum logic [2:0]
	{
		amp_gain_1,
		amp_gain_1p5,
		amp_gain_2,
		amp_gain_4,
		amp_gain_9
	} amp_gain_e;

	// source of a conversion
	typedef enum logic [1:0]
	{
		chan_aux,
		chan_tia,
		chan_temp
	} chan_kind_e;

endpackage : trim_pkg

// File: logic/trim_offset_sub.sv
/*
 * Offset stage: scales a conversion code to quarter-code units and takes
 * the signed offset trim off it.
 * Assumes an unsigned 16-bit code and a 15-bit two's complement trim.
 */
`timescale 1ns/1ps
`include "trim_regs.svh"

module trim_offset_sub
(
	input  wire logic [`CODE_W-1:0]       code_in,    // raw conversion code
	input  wire logic [`TRIM_FIELD_W-1:0] offset_in,  // quarter-code trim
	output logic signed [`QTR_W-1:0]      qtr_out     // code*4 - trim
);

	logic signed [`QTR_W-1:0] code_q;
	logic signed [`QTR_W-1:0] offs_q;

	// widen both operands to the quarter-code word
	assign code_q = $signed({2'b00, code_in, 2'b00});
	assign offs_q = $signed({{(`QTR_W-`TRIM_FIELD_W){offset_in[`TRIM_FIELD_MSB]}},
		offset_in});

	// 0x0001 takes off a quarter code, 0x7fff adds one back
	assign qtr_out = code_q - offs_q;

endmodule : trim_offset_sub

// File: logic/trim_gain_mul.sv
/*
 * Gain stage: multiplies the offset-corrected quarter-code value by the
 * gain trim and saturates the outcome to the code range.
 * Assumes a value from the offset stage and an unsigned 15-bit gain.
 */
`timescale 1ns/1ps
`include "trim_regs.svh"

module trim_gain_mul
(
	input  wire logic signed [`QTR_W-1:0] qtr_in,    // quarter-code value
	input  wire logic [`TRIM_FIELD_W-1:0] gain_in,   // gain trim code
	output logic [`CODE_W-1:0]            code_out,  // corrected code
	output logic                          sat_out    // clipped at a bound
);

	logic signed [`PROD_W-1:0] prod;
	logic signed [`PROD_W-1:0] scaled;

	// factor is gain/16384, step one part in 16384
	assign prod   = qtr_in * $signed({1'b0, gain_in});
	assign scaled = prod >>> `TRIM_SHIFT;

	// clip instead of wrapping; zero gain forces a zero result
	always_comb
	begin
		code_out = scaled[`CODE_W-1:0];
		sat_out  = 1'b0;
		if (gain_in == `TRIM_GAIN_ZERO)
		begin
			code_out = '0;
		end
		else if (scaled < 0)
		begin
			code_out = '0;
			sat_out  = 1'b1;
		end
		else if (scaled > $signed({20'h0, `CODE_MAX}))
		begin
			code_out = `CODE_MAX;
			sat_out  = 1'b1;
		end
	end

endmodule : trim_gain_mul

// File: logic/aux_gain_offset_trim.sv
/*
 * Gain and offset correction of conversion results on the auxiliary
 * channels, with its trim registers on an AHB-Lite slave port.
 * Assumes one 10 MHz clock, synchronous reset and a single bus master
 * doing whole-word single transfers; conversions arrive as one-cycle
 * strobes with their gain setting and channel kind.
 */
`timescale 1ns/1ps
`include "trim_regs.svh"

module aux_gain_offset_trim
	import trim_pkg::*;
(
	input  wire logic                clock,        // 10 MHz system clock
	input  wire logic                srst,         // synchronous reset
	input  wire logic                hsel,         // slave select
	input  wire logic [31:0]         haddr,        // byte address
	input  wire logic [1:0]          htrans,       // transfer type
	input  wire logic                hwrite,       // write when high
	input  wire logic [2:0]          hsize,        // transfer size
	input  wire logic [31:0]         hwdata,       // write data
	input  wire logic                hready,       // bus ready
	output logic                     hreadyout,    // slave ready
	output logic                     hresp,        // always okay
	output logic [31:0]              hrdata,       // read data
	input  wire logic                sample_valid, // conversion strobe
	input  wire logic [15:0]         sample_code,  // conversion_result
	input  wire trim_pkg::amp_gain_e sample_gain,  // amplifier gain
	input  wire trim_pkg::chan_kind_e sample_chan, // channel kind
	output logic                     result_valid, // corrected strobe
	output logic [15:0]              result_code,  // corrected result
	output logic                     result_sat    // result was clipped
);

	// ahb-lite transfer codes and the one size taken
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ    = 2'b11;
	localparam logic [2:0] HSIZE_WORD    = 3'b010;

	// trim registers, field bits only
	logic [`TRIM_FIELD_W-1:0] gain_two_r;
	logic [`TRIM_FIELD_W-1:0] gain_four_r;
	logic [`TRIM_FIELD_W-1:0] offset_four_r;

	// data phase bookkeeping
	logic        wr_pend_r;
	logic [31:0] wr_addr_r;
	logic        addr_take;
	logic        wr_take;
	logic        wr_gain_two;
	logic        wr_gain_four;
	logic        wr_offset_four;

	// read path
	logic [31:0] rd_word;
	logic [31:0] rd_field;
	logic [31:0] hrdata_r;
	logic        hreadyout_r;
	logic        hresp_r;

	// trim selection
	logic                     trim_apply;
	logic [`TRIM_FIELD_W-1:0] gain_sel;
	logic [`TRIM_FIELD_W-1:0] offset_sel;

	// pipeline stage one: captured conversion and trims
	logic                     s1_valid_r;
	logic [`CODE_W-1:0]       s1_code_r;
	logic [`TRIM_FIELD_W-1:0] s1_gain_r;
	logic [`TRIM_FIELD_W-1:0] s1_offset_r;
	logic                     s1_trim_r;

	// pipeline stage two: offset-corrected value
	logic                     s2_valid_r;
	logic signed [`QTR_W-1:0] s2_qtr_r;
	logic [`TRIM_FIELD_W-1:0] s2_gain_r;
	logic                     s2_trim_r;
	logic signed [`QTR_W-1:0] qtr_nxt;

	// gain stage outcome
	logic [`CODE_W-1:0] code_nxt;
	logic               sat_nxt;

	// output and status flops
	logic               result_valid_r;
	logic [`CODE_W-1:0] result_code_r;
	logic               result_sat_r;
	logic               last_trim_r;

	// address phase accepted when selected, active and bus ready
	assign addr_take = hsel && hready &&
		(htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign wr_take   = addr_take && hwrite && (hsize == HSIZE_WORD);

	// decode the data phase write to one trim register
	assign wr_gain_two    = wr_pend_r &&
		(wr_addr_r == `OFS_GAIN_TRIM_AMP_GAIN_TWO);
	assign wr_gain_four   = wr_pend_r &&
		(wr_addr_r == `OFS_GAIN_TRIM_AMP_GAIN_FOUR);
	assign wr_offset_four = wr_pend_r &&
		(wr_addr_r == `OFS_OFFSET_TRIM_AMP_GAIN_FOUR);

	// remember a pending write for its data phase
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 32'h0000_0000;
		end
		else if (hready)
		begin
			wr_pend_r <= wr_take;
			wr_addr_r <= haddr;
		end
	end

	// register writes in the data phase, field bits only
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			gain_two_r    <= `TRIM_FIELD_W'(`RST_GAIN_TRIM);
			gain_four_r   <= `TRIM_FIELD_W'(`RST_GAIN_TRIM);
			offset_four_r <= `TRIM_FIELD_W'(`RST_OFFSET_TRIM);
		end
		else
		begin
			if (wr_gain_two)
				gain_two_r <= hwdata[`TRIM_FIELD_MSB:0];
			if (wr_gain_four)
				gain_four_r <= hwdata[`TRIM_FIELD_MSB:0];
			if (wr_offset_four)
				offset_four_r <= hwdata[`TRIM_FIELD_MSB:0];
		end
	end

	// read mux; upper bits and unmapped words read as zero
	// status word is read only
	always_comb
	begin
		rd_field = 32'h0000_0000;
		case (haddr)
			`OFS_GAIN_TRIM_AMP_GAIN_TWO:
				rd_field = {17'h0_0000, gain_two_r};
			`OFS_GAIN_TRIM_AMP_GAIN_FOUR:
				rd_field = {17'h0_0000, gain_four_r};
			`OFS_OFFSET_TRIM_AMP_GAIN_FOUR:
				rd_field = {17'h0_0000, offset_four_r};
			`OFS_TRIM_STATUS:
				rd_field = {14'h0000, last_trim_r, result_sat_r,
					result_code_r};
			default:
				rd_field = 32'h0000_0000;
		endcase
	end

	// a write in flight to the word being read shows its new value
	// keeps a write followed at once by a read coherent
	always_comb
	begin
		rd_word = rd_field;
		if (wr_pend_r && (wr_addr_r == haddr) &&
			(haddr != `OFS_TRIM_STATUS))
		begin
			case (haddr)
				`OFS_GAIN_TRIM_AMP_GAIN_TWO,
				`OFS_GAIN_TRIM_AMP_GAIN_FOUR,
				`OFS_OFFSET_TRIM_AMP_GAIN_FOUR:
					rd_word = hwdata & `TRIM_FIELD_MASK;
				default:
					rd_word = rd_field;
			endcase
		end
	end

	// read data is captured at the address phase edge
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			hrdata_r <= 32'h0000_0000;
		end
		else if (addr_take && !hwrite)
		begin
			hrdata_r <= rd_word;
		end
	end

	// zero wait states and an okay answer on every transfer
	// every register answers at once, so no stall logic
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end
		else
		begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end
	end

	// pick the trims for the gain in force and the channel kind
	// other gains and channels pass through at unity
	always_comb
	begin
		trim_apply = 1'b0;
		gain_sel   = `TRIM_GAIN_UNITY;
		offset_sel = `TRIM_OFFSET_NONE;
		if (sample_chan == chan_aux)
		begin
			case (sample_gain)
				amp_gain_2:
				begin
					trim_apply = 1'b1;
					gain_sel   = gain_two_r;
				end
				amp_gain_4:
				begin
					trim_apply = 1'b1;
					gain_sel   = gain_four_r;
					offset_sel = offset_four_r;
				end
				default:
				begin
					trim_apply = 1'b0;
					gain_sel   = `TRIM_GAIN_UNITY;
					offset_sel = `TRIM_OFFSET_NONE;
				end
			endcase
		end
	end

	// stage one: capture the conversion with its trims
	// trims taken here, so a later write spares this sample
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			s1_valid_r  <= 1'b0;
			s1_code_r   <= '0;
			s1_gain_r   <= `TRIM_GAIN_UNITY;
			s1_offset_r <= `TRIM_OFFSET_NONE;
			s1_trim_r   <= 1'b0;
		end
		else
		begin
			s1_valid_r <= sample_valid;
			if (sample_valid)
			begin
				s1_code_r   <= sample_code;
				s1_gain_r   <= gain_sel;
				s1_offset_r <= offset_sel;
				s1_trim_r   <= trim_apply;
			end
		end
	end

	// offset correction in quarter codes
	trim_offset_sub u_offset
	(
		.code_in   (s1_code_r),
		.offset_in (s1_offset_r),
		.qtr_out   (qtr_nxt)
	);

	// stage two: hold the offset-corrected value
	// quarter-code word has room for the worst offset
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			s2_valid_r <= 1'b0;
			s2_qtr_r   <= '0;
			s2_gain_r  <= `TRIM_GAIN_UNITY;
			s2_trim_r  <= 1'b0;
		end
		else
		begin
			s2_valid_r <= s1_valid_r;
			if (s1_valid_r)
			begin
				s2_qtr_r  <= qtr_nxt;
				s2_gain_r <= s1_gain_r;
				s2_trim_r <= s1_trim_r;
			end
		end
	end

	// gain after offset, clipped to the code range
	// clipping keeps a large trim from wrapping round
	trim_gain_mul u_gain
	(
		.qtr_in   (s2_qtr_r),
		.gain_in  (s2_gain_r),
		.code_out (code_nxt),
		.sat_out  (sat_nxt)
	);

	// stage three: corrected result and status
	// status bits are held together with the result
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			result_valid_r <= 1'b0;
			result_code_r  <= '0;
			result_sat_r   <= 1'b0;
			last_trim_r    <= 1'b0;
		end
		else
		begin
			result_valid_r <= s2_valid_r;
			if (s2_valid_r)
			begin
				result_code_r <= code_nxt;
				result_sat_r  <= sat_nxt;
				last_trim_r   <= s2_trim_r;
			end
		end
	end

	// every output straight from a flop
	assign hreadyout    = hreadyout_r;
	assign hresp        = hresp_r;
	assign hrdata       = hrdata_r;
	assign result_valid = result_valid_r;
	assign result_code  = result_code_r;
	assign result_sat   = result_sat_r;

endmodule : aux_gain_offset_trim

// File: bench/trim_chk_asserts.sv
/*
 * port checker of the auxiliary trim block: latency, pass-through,
 * clipping, holding and bus answers.
 * assumes it is bound to aux_gain_offset_trim, one clock domain.
 */
`timescale 1ns/1ps

module trim_chk
	import trim_pkg::*;
(
	input wire logic                 clock,        // system clock
	input wire logic                 srst,         // sync reset
	input wire logic                 hreadyout,    // slave ready
	input wire logic                 hresp,        // response
	input wire logic [31:0]          hrdata,       // read data
	input wire logic                 sample_valid, // conversion strobe
	input wire logic [15:0]          sample_code,  // raw code
	input wire trim_pkg::amp_gain_e  sample_gain,  // amplifier gain
	input wire trim_pkg::chan_kind_e sample_chan,  // channel kind
	input wire logic                 result_valid, // corrected strobe
	input wire logic [15:0]          result_code,  // corrected code
	input wire logic                 result_sat    // clipped flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	// a sample that no trim applies to
	sequence s_untrimmed;
		sample_valid && (sample_chan != chan_aux ||
			!(sample_gain inside {amp_gain_2, amp_gain_4}));
	endsequence

	// result appears a fixed three edges after its sample
	AST_LAT: assert property (sample_valid |-> ##3 result_valid)
		else $error("result strobe missing");
	AST_PULSE: assert property (result_valid |-> $past(sample_valid, 3))
		else $error("result strobe without sample");
	AST_PASS: assert property (s_untrimmed |-> ##3
		result_code == $past(sample_code, 3) && !result_sat)
		else $error("untrimmed sample altered");
	AST_CLIP: assert property (result_valid && result_sat |->
		result_code == 16'h0000 || result_code == 16'hffff)
		else $error("clipped result off the bounds");
	AST_HOLD: assert property (!result_valid |->
		$stable(result_code) && $stable(result_sat))
		else $error("result changed without strobe");
	AST_RSVD: assert property (hrdata[31:18] == 14'h0000)
		else $error("reserved read bits set");
	AST_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not ready okay");
	AST_RST: assert property ($fell(srst) |-> hrdata == 32'h0000_0000 &&
		result_code == 16'h0000 && !result_valid && !result_sat)
		else $error("outputs not cleared by reset");
endmodule : trim_chk

bind aux_gain_offset_trim trim_chk i_trim_chk (.clock, .srst,
	.hreadyout, .hresp, .hrdata, .sample_valid, .sample_code,
	.sample_gain, .sample_chan, .result_valid, .result_code, .result_sat);

// File: bench/aux_gain_offset_trim_tb.sv
/*
 * self-checking bench of the auxiliary trim block: register access
 * over ahb-lite and table driven conversions.
 * assumes the block is the only slave, its hreadyout is hready.
 */
`timescale 1ns/1ps
`include "trim_regs.svh"

module aux_gain_offset_trim_tb;
	import trim_pkg::*;
	logic       clock = 0, srst = 1, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0;
	logic        sample_valid = 0, hreadyout, hresp;
	logic [15:0] sample_code = 0, result_code;
	amp_gain_e   sample_gain = amp_gain_1;
	chan_kind_e  sample_chan = chan_aux;
	logic        result_valid, result_sat;
	logic [14:0] g2 = 15'h4000, g4 = 15'h4000, off = 15'h0000;
	logic [14:0] gc [7] = '{15'h0000, 15'h2000, 15'h4000, 15'h4001,
		15'h7fff, 15'h0001, 15'h3fff};
	logic [14:0] oc [5] = '{15'h0001, 15'h7fff, 15'h3fff, 15'h4000,
		15'h0000};
	// fixed results of code 0x8000 for each entry of gc
	logic [15:0] ge [7] = '{16'h0000, 16'h4000, 16'h8000, 16'h8002,
		16'hfffe, 16'h0002, 16'h7ffe};
	logic [2:0]  hsize = 3'b010;
	int          num_errors = 0, n_tests = 0, cyc = 0;

	// free running clock
	initial forever #50 clock = ~clock;

	aux_gain_offset_trim i_aux_gain_offset_trim (.clock, .srst, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .sample_valid,
		.sample_code, .sample_gain, .sample_chan, .result_valid,
		.result_code, .result_sat);

	// verdict and end of run
	task summarize;
		$display("errors=%0d tests=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	// one comparison
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// single transfer: address phase, then data phase
	task bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask : rd

	// writes all three trims and keeps a copy
	task setregs(input logic [14:0] a, input logic [14:0] b,
		input logic [14:0] c);
		g2 = a;
		g4 = b;
		off = c;
		wr(`OFS_GAIN_TRIM_AMP_GAIN_TWO, {17'h0, a});
		wr(`OFS_GAIN_TRIM_AMP_GAIN_FOUR, {17'h0, b});
		wr(`OFS_OFFSET_TRIM_AMP_GAIN_FOUR, {17'h0, c});
	endtask : setregs

	// expected {sat, code}: offset off first, gain next, then clip
	function automatic logic [16:0] ref_calc(input logic [15:0] c,
		input logic [14:0] o, input logic [14:0] g);
		longint y;
		y = ((longint'(c) * 4 - longint'($signed(o))) * longint'(g)) >>> 16;
		if (y < 0)
			return {1'b1, 16'h0000};
		if (y > 65535)
			return {1'b1, 16'hffff};
		return {1'b0, y[15:0]};
	endfunction : ref_calc

	// one conversion, result checked while its strobe stands
	task run(input logic [15:0] c, input amp_gain_e g, input chan_kind_e k);
		logic [16:0] e;
		e = {1'b0, c};
		if (k == chan_aux && g == amp_gain_2)
			e = ref_calc(c, 15'h0000, g2);
		if (k == chan_aux && g == amp_gain_4)
			e = ref_calc(c, off, g4);
		sample_valid <= 1'b1;
		sample_code <= c;
		sample_gain <= g;
		sample_chan <= k;
		@(posedge clock);
		sample_valid <= 1'b0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk({14'h0, result_valid, result_sat, result_code}, {15'h1, e});
		@(posedge clock);
	endtask : run

	// hang guard
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			num_errors++;
			summarize();
		end
	end

	// main sequence
	initial
	begin
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		rd(`OFS_GAIN_TRIM_AMP_GAIN_TWO, `RST_GAIN_TRIM);
		rd(`OFS_GAIN_TRIM_AMP_GAIN_FOUR, `RST_GAIN_TRIM);
		rd(`OFS_OFFSET_TRIM_AMP_GAIN_FOUR, `RST_OFFSET_TRIM);
		rd(32'h0000_2280, 32'h0);
		run(16'h1234, amp_gain_4, chan_aux);
		wr(`OFS_GAIN_TRIM_AMP_GAIN_TWO, 32'hffff_ffff);
		rd(`OFS_GAIN_TRIM_AMP_GAIN_TWO, 32'h0000_7fff);
		// a byte sized write must leave the register alone
		hsize <= 3'b000;
		wr(`OFS_GAIN_TRIM_AMP_GAIN_FOUR, 32'h0000_0001);
		hsize <= 3'b010;
		rd(`OFS_GAIN_TRIM_AMP_GAIN_FOUR, `RST_GAIN_TRIM);
		// every listed gain code at gain two
		foreach (gc[i])
		begin
			setregs(gc[i], 15'h4000, 15'h0000);
			run(16'h8000, amp_gain_2, chan_aux);
			chk({16'h0, result_code}, {16'h0, ge[i]});
		end
		// every listed offset code at gain four
		foreach (oc[i])
		begin
			setregs(15'h4000, 15'h7fff, oc[i]);
			rd(`OFS_OFFSET_TRIM_AMP_GAIN_FOUR, {17'h0, oc[i]});
			run(16'h1000, amp_gain_4, chan_aux);
		end
		setregs(15'h2000, 15'h7fff, 15'h0001);
		run(16'h0000, amp_gain_4, chan_aux);
		run(16'hffff, amp_gain_4, chan_aux);
		rd(`OFS_TRIM_STATUS, 32'h0003_ffff);
		run(16'hffff, amp_gain_2, chan_aux);
		// no trim on other channels or gains
		for (int i = 0; i < 5; i++)
		begin
			run(16'h8000, amp_gain_e'(i), chan_tia);
			run(16'h8000, amp_gain_e'(i), chan_temp);
		end
		run(16'h8000, amp_gain_1, chan_aux);
		run(16'h8000, amp_gain_9, chan_aux);
		rd(`OFS_TRIM_STATUS, 32'h0000_8000);
		summarize();
	end
endmodule : aux_gain_offset_trim_tb
